//--- sec_event_capture.sv
// Event capture enables and transceiver / local input event flags
//
// Contract
// R01: Set transceiver failure flag on transceiver shutdown, never in deep low-power state.
// R02: Set bus wake-up flag on bus wake while transceiver is offline.
// R03: Set local-input rise flag, bit 1 at 64h, on a low-to-high input edge.
// R04: Set local-input fall flag, bit 0 at 64h, on a high-to-low input edge.
// R05: System enable bit 2 at 04h gates overtemperature warning capture.
// R06: System enable bit 1 switches serial failure detection on or off.
// R07: Supply enable bit 2 at 1Ch gates secondary supply overvoltage capture.
// R08: Supply enable bit 1 gates secondary supply undervoltage capture.
// R09: Supply enable bit 0 gates primary regulator undervoltage capture.
// R10: Transceiver enable bit 4 at 23h switches bus-silence detection on or off.
// R11: Transceiver enable bit 1 gates transceiver failure capture.
// R12: Transceiver enable bit 0 gates bus wake-up capture.
// R13: Local enable bit 1 at 4Ch gates rising-edge detection.
// R14: Local enable bit 0 at 4Ch gates falling-edge detection.
// R15: Silence flag sets after timeout without activity, if enabled and bus was active.
// R16: Serial failure on bad bit count, illegal mode or locked write, not asleep.
// R17: Captured flags stay set until software clears them by writing; serialFailFlag clears on the serialFailClear input instead.
`timescale 1ns/1ps
module sec_event_capture
   import sec_pkg::*;
#(
   parameter int SILENCE_CYCLES = SEC_SILENCE_CYCLES
) (
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic [6:0] regAddr,
   input  wire logic       regWrEn,
   input  wire logic       regRdEn,
   input  wire logic [7:0] regWrData,
   output logic      [7:0] regRdData,
   input  wire logic       deepSleep,
   input  wire logic       transceiverOffFault,
   input  wire logic       transceiverOffline,
   input  wire logic       busWakeEvent,
   input  wire logic       busActive,
   input  wire logic       wakePin,
   input  wire logic       overtempWarn,
   input  wire logic       secSupplyOver,
   input  wire logic       secSupplyUnder,
   input  wire logic       primaryUnder,
   input  wire logic       serialFrameEnd,
   input  wire logic [5:0] serialBitCount,
   input  wire logic       serialIllegalMode,
   input  wire logic       serialLockedWrite,
   input  wire logic       serialFailClear,
   output logic            overtempCapture,
   output logic            secSupplyOverCapture,
   output logic            secSupplyUnderCapture,
   output logic            primaryUnderCapture,
   output logic            serialFailFlag
);

   ////////////////////////////////////////////////////////////////////////////
   // Set wins over a clear arriving in the same cycle
   function automatic logic [7:0] stickyNext(input logic [7:0] cur,
                                             input logic [7:0] setBits,
                                             input logic [7:0] clrBits);
      stickyNext = (cur & ~clrBits) | setBits;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] sysEn_reg;
   logic [7:0] sysEn_next;
   logic [7:0] supEn_reg;
   logic [7:0] supEn_next;
   logic [7:0] trxEn_reg;
   logic [7:0] trxEn_next;
   logic [7:0] locEn_reg;
   logic [7:0] locEn_next;
   logic [7:0] trxStat_reg;
   logic [7:0] trxStat_next;
   logic [7:0] locStat_reg;
   logic [7:0] locStat_next;
   logic [7:0] rdData_reg;
   logic [7:0] rdData_next;
   logic       wakePrev_reg;
   logic       wakePrev_next;
   logic       wakeValid_reg;
   logic       wakeValid_next;
   logic [3:0] capt_reg;
   logic [3:0] capt_next;
   logic       serFail_reg;
   logic       serFail_next;
   logic       silencePulse;
   logic [7:0] trxSet;
   logic [7:0] locSet;
   logic [7:0] trxClr;
   logic [7:0] locClr;
   logic       badCount;
   logic       serialFault;

   ////////////////////////////////////////////////////////////////////////////
   sec_silence_timer #(
      .TIMEOUT_CYCLES(SILENCE_CYCLES)
   ) u_silence (
      .mclk        (mclk),
      .srst        (srst),
      .enable      (trxEn_reg[SEC_BIT_SILENCE]), // [R10]
      .busActive   (busActive),
      .silencePulse(silencePulse)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register writes and reads
   always_comb begin
      sysEn_next  = sysEn_reg;
      supEn_next  = supEn_reg;
      trxEn_next  = trxEn_reg;
      locEn_next  = locEn_reg;
      trxClr      = 8'h00;
      locClr      = 8'h00;
      rdData_next = rdData_reg;
      if (regWrEn) begin
         unique case (regAddr)
            SEC_ADDR_SYS_EN:   sysEn_next = regWrData & SEC_MASK_SYS_EN;
            SEC_ADDR_SUP_EN:   supEn_next = regWrData & SEC_MASK_SUP_EN;
            SEC_ADDR_TRX_EN:   trxEn_next = regWrData & SEC_MASK_TRX_EN;
            SEC_ADDR_LOC_EN:   locEn_next = regWrData & SEC_MASK_LOC_EN;
            SEC_ADDR_TRX_STAT: trxClr = regWrData & SEC_MASK_TRX_STAT; // [R17]
            SEC_ADDR_LOC_STAT: locClr = regWrData & SEC_MASK_LOC_STAT; // [R17]
            default: ;
         endcase
      end
      if (regRdEn) begin
         unique case (regAddr)
            SEC_ADDR_SYS_EN:   rdData_next = sysEn_reg;
            SEC_ADDR_SUP_EN:   rdData_next = supEn_reg;
            SEC_ADDR_TRX_EN:   rdData_next = trxEn_reg;
            SEC_ADDR_LOC_EN:   rdData_next = locEn_reg;
            SEC_ADDR_TRX_STAT: rdData_next = trxStat_reg;
            SEC_ADDR_LOC_STAT: rdData_next = locStat_reg;
            default:           rdData_next = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event capture into sticky flags
   always_comb begin
      trxSet = 8'h00;
      locSet = 8'h00;
      // Deep low-power state masks the shutdown report [R01]
      trxSet[SEC_BIT_TRX_FAIL] = transceiverOffFault && !deepSleep && trxEn_reg[SEC_BIT_TRX_FAIL]; // [R01] [R11]
      trxSet[SEC_BIT_BUS_WAKE] = busWakeEvent && transceiverOffline && trxEn_reg[SEC_BIT_BUS_WAKE]; // [R02] [R12]
      trxSet[SEC_BIT_SILENCE]  = silencePulse; // [R15]
      // First sample after reset only seeds the history, no false edge
      locSet[SEC_BIT_RISE] = wakeValid_reg && !wakePrev_reg && wakePin && locEn_reg[SEC_BIT_RISE]; // [R03] [R13]
      locSet[SEC_BIT_FALL] = wakeValid_reg && wakePrev_reg && !wakePin && locEn_reg[SEC_BIT_FALL]; // [R04] [R14]
      trxStat_next   = stickyNext(trxStat_reg, trxSet, trxClr); // [R17]
      locStat_next   = stickyNext(locStat_reg, locSet, locClr); // [R17]
      wakePrev_next  = wakePin;
      wakeValid_next = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gated system and supply events, handed on registered
   always_comb begin
      badCount = (serialBitCount != SEC_FRAME_BITS_A) && (serialBitCount != SEC_FRAME_BITS_B)
                 && (serialBitCount != SEC_FRAME_BITS_C);
      serialFault = ((serialFrameEnd && badCount) || serialIllegalMode || serialLockedWrite)
                    && !deepSleep && sysEn_reg[SEC_BIT_SERFAIL_EN]; // [R06] [R16]
      serFail_next = serialFault || (serFail_reg && !serialFailClear); // [R16]
      capt_next[0] = overtempWarn && sysEn_reg[SEC_BIT_OTW_EN]; // [R05]
      capt_next[1] = secSupplyOver && supEn_reg[SEC_BIT_SEC_OVER]; // [R07]
      capt_next[2] = secSupplyUnder && supEn_reg[SEC_BIT_SEC_UNDER]; // [R08]
      capt_next[3] = primaryUnder && supEn_reg[SEC_BIT_PRIM_UNDER]; // [R09]
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (srst) begin
         sysEn_reg     <= SEC_RESET_VALUE;
         supEn_reg     <= SEC_RESET_VALUE;
         trxEn_reg     <= SEC_RESET_VALUE;
         locEn_reg     <= SEC_RESET_VALUE;
         trxStat_reg   <= SEC_RESET_VALUE;
         locStat_reg   <= SEC_RESET_VALUE;
         rdData_reg    <= 8'h00;
         wakePrev_reg  <= 1'b0;
         wakeValid_reg <= 1'b0;
         capt_reg      <= 4'h0;
         serFail_reg   <= 1'b0;
      end else begin
         sysEn_reg     <= sysEn_next;
         supEn_reg     <= supEn_next;
         trxEn_reg     <= trxEn_next;
         locEn_reg     <= locEn_next;
         trxStat_reg   <= trxStat_next;
         locStat_reg   <= locStat_next;
         rdData_reg    <= rdData_next;
         wakePrev_reg  <= wakePrev_next;
         wakeValid_reg <= wakeValid_next;
         capt_reg      <= capt_next;
         serFail_reg   <= serFail_next;
      end
   end

   assign regRdData             = rdData_reg;
   assign overtempCapture       = capt_reg[0];
   assign secSupplyOverCapture  = capt_reg[1];
   assign secSupplyUnderCapture = capt_reg[2];
   assign primaryUnderCapture   = capt_reg[3];
   assign serialFailFlag        = serFail_reg;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   sequence s_rise_seen;
      wakeValid_reg && !wakePrev_reg && wakePin && locEn_reg[SEC_BIT_RISE];
   endsequence
   sequence s_fall_seen;
      wakeValid_reg && wakePrev_reg && !wakePin && locEn_reg[SEC_BIT_FALL];
   endsequence

   property p_rise_sets;
      s_rise_seen |=> locStat_reg[SEC_BIT_RISE];
   endproperty
   a_rise_sets: assert property (p_rise_sets) else $error("rising edge not captured"); // [R03]

   property p_fall_sets;
      s_fall_seen |=> locStat_reg[SEC_BIT_FALL];
   endproperty
   a_fall_sets: assert property (p_fall_sets) else $error("falling edge not captured"); // [R04]

   property p_rise_gated;
      $rose(locStat_reg[SEC_BIT_RISE]) |-> $past(locEn_reg[SEC_BIT_RISE] && wakePin && !wakePrev_reg);
   endproperty
   a_rise_gated: assert property (p_rise_gated) else $error("rise flag without enabled edge"); // [R13]

   property p_fall_gated;
      $rose(locStat_reg[SEC_BIT_FALL]) |-> $past(locEn_reg[SEC_BIT_FALL] && !wakePin && wakePrev_reg);
   endproperty
   a_fall_gated: assert property (p_fall_gated) else $error("fall flag without enabled edge"); // [R14]

   property p_fail_cause;
      $rose(trxStat_reg[SEC_BIT_TRX_FAIL])
         |-> $past(transceiverOffFault && !deepSleep && trxEn_reg[SEC_BIT_TRX_FAIL]);
   endproperty
   a_fail_cause: assert property (p_fail_cause) else $error("failure flag set without cause"); // [R01]

   property p_fail_sets;
      (transceiverOffFault && !deepSleep && trxEn_reg[SEC_BIT_TRX_FAIL]) |=> trxStat_reg[SEC_BIT_TRX_FAIL];
   endproperty
   a_fail_sets: assert property (p_fail_sets) else $error("failure event lost"); // [R11]

   property p_wake_sets;
      (busWakeEvent && transceiverOffline && trxEn_reg[SEC_BIT_BUS_WAKE]) |=> trxStat_reg[SEC_BIT_BUS_WAKE];
   endproperty
   a_wake_sets: assert property (p_wake_sets) else $error("bus wake not captured"); // [R02]

   property p_wake_cause;
      $rose(trxStat_reg[SEC_BIT_BUS_WAKE])
         |-> $past(busWakeEvent && transceiverOffline && trxEn_reg[SEC_BIT_BUS_WAKE]);
   endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("bus wake flag without cause"); // [R12]

   property p_sticky;
      (trxStat_reg[SEC_BIT_TRX_FAIL] && !(regWrEn && regAddr == SEC_ADDR_TRX_STAT))
         |=> trxStat_reg[SEC_BIT_TRX_FAIL];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without write"); // [R17]

   property p_otw;
      overtempCapture |-> $past(overtempWarn && sysEn_reg[SEC_BIT_OTW_EN]);
   endproperty
   a_otw: assert property (p_otw) else $error("overtemp passed while disabled"); // [R05]

   property p_sup;
      (secSupplyOver && supEn_reg[SEC_BIT_SEC_OVER]) |=> secSupplyOverCapture;
   endproperty
   a_sup: assert property (p_sup) else $error("overvoltage not passed"); // [R07]

   property p_serfail;
      (serialFrameEnd && badCount && !deepSleep && sysEn_reg[SEC_BIT_SERFAIL_EN]) |=> serialFailFlag [*2];
   endproperty
   a_serfail: assert property (p_serfail) else $error("serial failure not held"); // [R16]

   // Flag may only rise from a cycle that was enabled and awake
   property p_serfail_gated;
      $rose(serialFailFlag) |-> $past(sysEn_reg[SEC_BIT_SERFAIL_EN] && !deepSleep);
   endproperty
   a_serfail_gated: assert property (p_serfail_gated) else $error("serial failure while disabled"); // [R06]

   property p_sup_under;
      (secSupplyUnder && supEn_reg[SEC_BIT_SEC_UNDER]) |=> secSupplyUnderCapture;
   endproperty
   a_sup_under: assert property (p_sup_under) else $error("undervoltage not passed"); // [R08]

   property p_prim_under;
      (primaryUnder && supEn_reg[SEC_BIT_PRIM_UNDER]) |=> primaryUnderCapture;
   endproperty
   a_prim_under: assert property (p_prim_under) else $error("primary undervoltage not passed"); // [R09]

   property p_silence_sets;
      silencePulse |=> trxStat_reg[SEC_BIT_SILENCE];
   endproperty
   a_silence_sets: assert property (p_silence_sets) else $error("silence timeout not captured"); // [R15]

   property p_silence_gated;
      silencePulse |-> $past(trxEn_reg[SEC_BIT_SILENCE]);
   endproperty
   a_silence_gated: assert property (p_silence_gated) else $error("silence flagged while disabled"); // [R10]

endmodule // sec_event_capture

//--- sec_pkg.sv
// Constants shared by the event capture block
package sec_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam logic [6:0] SEC_ADDR_SYS_EN   = 7'h04;
   localparam logic [6:0] SEC_ADDR_SUP_EN   = 7'h1C;
   localparam logic [6:0] SEC_ADDR_TRX_EN   = 7'h23;
   localparam logic [6:0] SEC_ADDR_LOC_EN   = 7'h4C;
   localparam logic [6:0] SEC_ADDR_TRX_STAT = 7'h63;
   localparam logic [6:0] SEC_ADDR_LOC_STAT = 7'h64;

   ////////////////////////////////////////////////////////////////////////////
   localparam int SEC_BIT_OTW_EN      = 2;
   localparam int SEC_BIT_SERFAIL_EN  = 1;
   localparam int SEC_BIT_SEC_OVER    = 2;
   localparam int SEC_BIT_SEC_UNDER   = 1;
   localparam int SEC_BIT_PRIM_UNDER  = 0;
   localparam int SEC_BIT_SILENCE     = 4;
   localparam int SEC_BIT_TRX_FAIL    = 1;
   localparam int SEC_BIT_BUS_WAKE    = 0;
   localparam int SEC_BIT_RISE        = 1;
   localparam int SEC_BIT_FALL        = 0;

   localparam logic [7:0] SEC_MASK_SYS_EN   = 8'h06;
   localparam logic [7:0] SEC_MASK_SUP_EN   = 8'h07;
   localparam logic [7:0] SEC_MASK_TRX_EN   = 8'h13;
   localparam logic [7:0] SEC_MASK_LOC_EN   = 8'h03;
   localparam logic [7:0] SEC_MASK_TRX_STAT = 8'h13;
   localparam logic [7:0] SEC_MASK_LOC_STAT = 8'h03;
   localparam logic [7:0] SEC_RESET_VALUE   = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   localparam logic [5:0] SEC_FRAME_BITS_A = 6'h10;
   localparam logic [5:0] SEC_FRAME_BITS_B = 6'h18;
   localparam logic [5:0] SEC_FRAME_BITS_C = 6'h20;

   ////////////////////////////////////////////////////////////////////////////
   localparam int SEC_CLK_PERIOD_NS     = 20;
   localparam int SEC_SILENCE_TIMEOUT_US = 1000;
   localparam int SEC_SILENCE_CYCLES    = (SEC_SILENCE_TIMEOUT_US * 1000) / SEC_CLK_PERIOD_NS;

   typedef enum logic {
      SEC_IDLE  = 1'b0,
      SEC_ARMED = 1'b1
   } sec_silence_state_type;

endpackage

//--- sec_silence_timer.sv
// Bus silence timeout counter
`timescale 1ns/1ps
module sec_silence_timer
   import sec_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = SEC_SILENCE_CYCLES
) (
   input  wire logic mclk,
   input  wire logic srst,
   input  wire logic enable,
   input  wire logic busActive,
   output logic      silencePulse
);

   localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYCLES - 1);

   sec_silence_state_type state_reg;
   sec_silence_state_type state_next;
   logic [CNT_W-1:0]      count_reg;
   logic [CNT_W-1:0]      count_next;
   logic                  pulse_reg;
   logic                  pulse_next;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      pulse_next = 1'b0;
      unique case (state_reg)
         SEC_IDLE: begin
            // Only a bus that was active can fall silent [R15]
            if (enable && busActive) begin
               state_next = SEC_ARMED;
               count_next = '0;
            end
         end
         SEC_ARMED: begin
            if (!enable) begin
               state_next = SEC_IDLE;
            end else if (busActive) begin
               count_next = '0;
            end else if (count_reg == LAST) begin
               pulse_next = 1'b1; // [R15]
               state_next = SEC_IDLE;
            end else begin
               count_next = count_reg + CNT_W'(1);
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         state_reg <= SEC_IDLE;
         count_reg <= '0;
         pulse_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         pulse_reg <= pulse_next;
      end
   end

   assign silencePulse = pulse_reg;

   ////////////////////////////////////////////////////////////////////////////
   property p_silence_cause;
      @(posedge mclk) disable iff (srst)
      silencePulse |-> $past(state_reg == SEC_ARMED && !busActive && enable && count_reg == LAST);
   endproperty
   a_silence_cause: assert property (p_silence_cause) else $error("silence pulse without timeout"); // [R15]

   property p_silence_fires;
      @(posedge mclk) disable iff (srst)
      (state_reg == SEC_ARMED && enable && !busActive && count_reg == LAST) |=> silencePulse;
   endproperty
   a_silence_fires: assert property (p_silence_fires) else $error("silence timeout missed"); // [R15]

endmodule // sec_silence_timer

//--- sec_event_capture_tb.sv
// Self-checking bench for the event capture block
`timescale 1ns/1ps
module tb;
   import sec_pkg::*;

   localparam int SIL = 20;  // Short silence timeout keeps the run brief

   logic       mclk = 1'b0;
   logic       srst = 1'b1;
   logic [6:0] regAddr = 7'h00;
   logic       regWrEn = 1'b0;
   logic       regRdEn = 1'b0;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] regRdData;
   logic       deepSleep = 1'b0;
   logic       transceiverOffFault = 1'b0;
   logic       transceiverOffline = 1'b0;
   logic       busWakeEvent = 1'b0;
   logic       busActive = 1'b0;
   logic       wakePin = 1'b0;
   logic [3:0] rawEv = 4'h0;
   wire  [3:0] capOut;
   logic       serialFrameEnd = 1'b0;
   logic [5:0] serialBitCount = 6'h00;
   logic       serialIllegalMode = 1'b0;
   logic       serialLockedWrite = 1'b0;
   logic       serialFailClear = 1'b0;
   logic       serialFailFlag;
   logic [7:0] rdVal;
   int         failures = 0;
   int         totalChecks = 0;

   typedef struct packed {logic [6:0] a; logic [7:0] w; logic [7:0] r;} sec_reg_row_type;
   typedef struct packed {logic [7:0] sys; logic [7:0] sup; logic [3:0] in; logic [3:0] out;} sec_cap_row_type;
   // Reserved bits and an unmapped address must read back zero
   sec_reg_row_type regRows [5] = '{'{7'h04, 8'hFF, 8'h06}, '{7'h1C, 8'hFF, 8'h07},
      '{7'h23, 8'hFF, 8'h13}, '{7'h4C, 8'hFF, 8'h03}, '{7'h10, 8'hFF, 8'h00}};
   // Order of capture bits: overtemp, supply over, supply under, primary under
   sec_cap_row_type capRows [5] = '{'{8'h06, 8'h07, 4'hF, 4'hF}, '{8'h00, 8'h00, 4'hF, 4'h0},
      '{8'h04, 8'h05, 4'hF, 4'hD}, '{8'h00, 8'h02, 4'hF, 4'h2}, '{8'h06, 8'h07, 4'h5, 4'h5}};

   always #10 mclk = ~mclk;

   sec_event_capture #(.SILENCE_CYCLES(SIL)) i_dut (
      .mclk                  (mclk),
      .srst                  (srst),
      .regAddr               (regAddr),
      .regWrEn               (regWrEn),
      .regRdEn               (regRdEn),
      .regWrData             (regWrData),
      .regRdData             (regRdData),
      .deepSleep             (deepSleep),
      .transceiverOffFault   (transceiverOffFault),
      .transceiverOffline    (transceiverOffline),
      .busWakeEvent          (busWakeEvent),
      .busActive             (busActive),
      .wakePin               (wakePin),
      .overtempWarn          (rawEv[3]),
      .secSupplyOver         (rawEv[2]),
      .secSupplyUnder        (rawEv[1]),
      .primaryUnder          (rawEv[0]),
      .serialFrameEnd        (serialFrameEnd),
      .serialBitCount        (serialBitCount),
      .serialIllegalMode     (serialIllegalMode),
      .serialLockedWrite     (serialLockedWrite),
      .serialFailClear       (serialFailClear),
      .overtempCapture       (capOut[3]),
      .secSupplyOverCapture  (capOut[2]),
      .secSupplyUnderCapture (capOut[1]),
      .primaryUnderCapture   (capOut[0]),
      .serialFailFlag        (serialFailFlag)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tk(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // Strobe dropped with a free edge after it, so back-to-back calls never collide
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      tk(1);
      regWrEn <= 1'b0;
      tk(1);
   endtask

   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      regAddr <= a;
      regRdEn <= 1'b1;
      tk(1);
      regRdEn <= 1'b0;
      tk(1);
      d = regRdData;
   endtask

   task automatic trx(input logic fault, input logic wake);
      transceiverOffFault <= fault;
      busWakeEvent <= wake;
      tk(1);
      transceiverOffFault <= 1'b0;
      busWakeEvent <= 1'b0;
      tk(1);
   endtask

   task automatic ser(input logic [5:0] cnt, input logic fe, input logic ill, input logic lk);
      serialBitCount <= cnt;
      serialFrameEnd <= fe;
      serialIllegalMode <= ill;
      serialLockedWrite <= lk;
      tk(1);
      serialFrameEnd <= 1'b0;
      serialIllegalMode <= 1'b0;
      serialLockedWrite <= 1'b0;
      tk(2);
   endtask

   task automatic sclr();
      serialFailClear <= 1'b1;
      tk(1);
      serialFailClear <= 1'b0;
      tk(1);
   endtask

   task automatic summarize();
      $display("checks %0d, mismatches %0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      tk(10);
      srst <= 1'b0;
      tk(1);
      foreach (regRows[i]) begin
         rd(regRows[i].a, rdVal);
         check(rdVal, SEC_RESET_VALUE);  // Reset value of each enable register and of the unmapped address
         wr(regRows[i].a, regRows[i].w);
         rd(regRows[i].a, rdVal);
         check(rdVal, regRows[i].r);
      end
      foreach (capRows[i]) begin
         wr(SEC_ADDR_SYS_EN, capRows[i].sys);
         wr(SEC_ADDR_SUP_EN, capRows[i].sup);
         rawEv <= capRows[i].in;
         tk(2);
         check({4'h0, capOut}, {4'h0, capRows[i].out});
         rawEv <= 4'h0;
         tk(2);
         check({4'h0, capOut}, 8'h00);
      end
      // Local input edges, rise enabled alone first
      wr(SEC_ADDR_LOC_EN, 8'h02);
      wakePin <= 1'b1;
      tk(2);
      wakePin <= 1'b0;
      tk(2);
      rd(SEC_ADDR_LOC_STAT, rdVal);
      check(rdVal, 8'h02);
      wr(SEC_ADDR_LOC_EN, 8'h03);
      wakePin <= 1'b1;
      tk(2);
      wakePin <= 1'b0;
      tk(2);
      rd(SEC_ADDR_LOC_STAT, rdVal);
      check(rdVal, 8'h03);
      wr(SEC_ADDR_LOC_STAT, 8'h00);
      rd(SEC_ADDR_LOC_STAT, rdVal);
      check(rdVal, 8'h03);
      wr(SEC_ADDR_LOC_STAT, 8'h01);
      rd(SEC_ADDR_LOC_STAT, rdVal);
      check(rdVal, 8'h02);
      wr(SEC_ADDR_LOC_STAT, 8'h02);
      // Transceiver failure and bus wake
      wr(SEC_ADDR_TRX_EN, 8'h03);
      trx(1'b0, 1'b1);
      rd(SEC_ADDR_TRX_STAT, rdVal);
      check(rdVal, 8'h00);
      transceiverOffline <= 1'b1;
      trx(1'b0, 1'b1);
      rd(SEC_ADDR_TRX_STAT, rdVal);
      check(rdVal, 8'h01);
      deepSleep <= 1'b1;
      trx(1'b1, 1'b0);
      rd(SEC_ADDR_TRX_STAT, rdVal);
      check(rdVal, 8'h01);
      deepSleep <= 1'b0;
      trx(1'b1, 1'b0);
      rd(SEC_ADDR_TRX_STAT, rdVal);
      check(rdVal, 8'h03);
      wr(SEC_ADDR_TRX_STAT, 8'h03);
      wr(SEC_ADDR_TRX_EN, 8'h00);
      trx(1'b1, 1'b1);
      rd(SEC_ADDR_TRX_STAT, rdVal);
      check(rdVal, 8'h00);
      // Silence: no flag before the bus was ever active
      wr(SEC_ADDR_TRX_EN, 8'h10);
      tk(2 * SIL);
      rd(SEC_ADDR_TRX_STAT, rdVal);
      check(rdVal, 8'h00);
      busActive <= 1'b1;
      tk(1);
      busActive <= 1'b0;
      tk(SIL / 2);
      rd(SEC_ADDR_TRX_STAT, rdVal);
      check(rdVal, 8'h00);
      tk(SIL);
      rd(SEC_ADDR_TRX_STAT, rdVal);
      check(rdVal, 8'h10);
      wr(SEC_ADDR_TRX_STAT, 8'h10);
      wr(SEC_ADDR_TRX_EN, 8'h00);
      busActive <= 1'b1;
      tk(1);
      busActive <= 1'b0;
      tk(2 * SIL);
      rd(SEC_ADDR_TRX_STAT, rdVal);
      check(rdVal, 8'h00);
      // Serial failure: legal counts, then each fault kind
      wr(SEC_ADDR_SYS_EN, 8'h02);
      ser(SEC_FRAME_BITS_A, 1'b1, 1'b0, 1'b0);
      ser(SEC_FRAME_BITS_B, 1'b1, 1'b0, 1'b0);
      ser(SEC_FRAME_BITS_C, 1'b1, 1'b0, 1'b0);
      check({7'h00, serialFailFlag}, 8'h00);
      ser(6'h11, 1'b1, 1'b0, 1'b0);
      check({7'h00, serialFailFlag}, 8'h01);
      ser(6'h10, 1'b1, 1'b0, 1'b0);
      check({7'h00, serialFailFlag}, 8'h01);
      sclr();
      check({7'h00, serialFailFlag}, 8'h00);
      ser(6'h10, 1'b0, 1'b1, 1'b0);
      check({7'h00, serialFailFlag}, 8'h01);
      sclr();
      ser(6'h10, 1'b0, 1'b0, 1'b1);
      check({7'h00, serialFailFlag}, 8'h01);
      sclr();
      deepSleep <= 1'b1;
      ser(6'h0F, 1'b1, 1'b1, 1'b1);
      check({7'h00, serialFailFlag}, 8'h00);
      deepSleep <= 1'b0;
      wr(SEC_ADDR_SYS_EN, 8'h00);
      ser(6'h0F, 1'b1, 1'b1, 1'b1);
      check({7'h00, serialFailFlag}, 8'h00);
      // Reset in mid-run clears enables again
      wr(SEC_ADDR_TRX_EN, 8'h13);
      srst <= 1'b1;
      tk(2);
      srst <= 1'b0;
      tk(1);
      rd(SEC_ADDR_TRX_EN, rdVal);
      check(rdVal, SEC_RESET_VALUE);  // Reset value after a second reset
      summarize();
   end

   // Whole sequence needs well under a thousand cycles
   initial begin
      tk(5000);
      failures++;
      summarize();
   end
endmodule  // tb
